/* File: common/mtr_pkg.sv */
// Constants, field positions and types of the memory type range lookup.
// Assumes a 32-bit classic Wishbone register bus and 36-bit physical addresses.
package mtr_pkg;

  // Widths
  localparam int PA_W = 36;
  localparam int WB_AW = 12;
  localparam int WB_DW = 32;
  localparam int NVAR_DEF = 8;
  localparam int NFIX = 8;

  // Register byte offsets; each 64-bit register is a low word then a high word
  localparam logic [WB_AW-1:0] OFS_CAP = 12'h000;
  localparam logic [WB_AW-1:0] OFS_DEF = 12'h008;
  localparam logic [WB_AW-1:0] OFS_FIX = 12'h040;
  localparam logic [WB_AW-1:0] OFS_VAR = 12'h100;
  localparam logic [WB_AW-1:0] FIX_STRIDE = 12'h008;
  localparam logic [WB_AW-1:0] VAR_STRIDE = 12'h010;

  // Field positions
  localparam int TYPE_MSB = 7;
  localparam int CAP_VCNT_MSB = 7;
  localparam int CAP_FIX_BIT = 8;
  localparam int CAP_WC_BIT = 10;
  localparam int DEF_FE_BIT = 10;
  localparam int MASK_V_BIT = 11;
  localparam int PAGE_LSB = 12;
  localparam int FIX_TOP_BIT = 20;
  localparam int FIX_REG_LSB = 17;
  localparam int FIX_SUB_LSB = 14;

  // Writable bits; all others read as zero
  localparam logic [63:0] DEF_WMASK = 64'h0000_0000_0000_04FF;
  localparam logic [63:0] BASE_WMASK = 64'h0000_000F_FFFF_F0FF;
  localparam logic [63:0] MASK_WMASK = 64'h0000_000F_FFFF_F800;
  localparam logic [63:0] FIX_WMASK = 64'hFFFF_FFFF_FFFF_FFFF;

  // Reset value of every range register
  localparam logic [63:0] RANGE_RST = 64'h0000_0000_0000_0000;

  typedef enum logic [7:0] {
    MTR_UC = 8'h00,
    MTR_WC = 8'h01,
    MTR_WT = 8'h04,
    MTR_WP = 8'h05,
    MTR_WB = 8'h06
  } mtr_cache_type;

  typedef enum logic [1:0] {
    MTR_SRC_DEFAULT = 2'h0,
    MTR_SRC_FIXED = 2'h1,
    MTR_SRC_VAR = 2'h3
  } mtr_src_type;

endpackage

/* File: common/mtr_pair_if.sv */
// Signals between the register bank and one base/mask pair comparator.
// Assumes one instance per variable pair.
interface mtr_pair_if;
  import mtr_pkg::*;
  logic [PA_W-1:0] addr;
  logic [63:0] base;
  logic [63:0] mask;
  logic hit;
  logic [TYPE_MSB:0] mtype;

  modport owner (output addr, output base, output mask, input hit, input mtype);
  modport match (input addr, input base, input mask, output hit, output mtype);
endinterface

/* File: core/mtr_pair_match.sv */
// Masked address compare of one variable base/mask pair.
// Assumes base and mask come straight from the register bank.
module mtr_pair_match (
  // Pair under test
  mtr_pair_if.match pair
);
  import mtr_pkg::*;

  wire [PA_W-1:PAGE_LSB] mask_bits;
  wire [PA_W-1:PAGE_LSB] addr_sel;
  wire [PA_W-1:PAGE_LSB] base_sel;
  wire pair_valid;

  assign mask_bits = pair.mask[PA_W-1:PAGE_LSB];
  // Any bit pattern allowed in the mask, so holes may repeat
  assign addr_sel = pair.addr[PA_W-1:PAGE_LSB] & mask_bits;
  assign base_sel = pair.base[PA_W-1:PAGE_LSB] & mask_bits;
  assign pair_valid = pair.mask[MASK_V_BIT];
  assign pair.hit = pair_valid && (addr_sel == base_sel);
  assign pair.mtype = pair.base[TYPE_MSB:0];
endmodule

/* File: core/mtr_range_lookup.sv */
// Memory type range register bank and address lookup.
// Assumes a classic Wishbone master and a lookup requester on clk_i.
// What this block does
// - Range registers are 64 bits, reached only as two bus words.
// - Fixed registers govern below 1 MB while enabled, variable pairs everywhere else.
// - Read-only capability register reports fixed support and pair count.
// - Access to an unimplemented address answers with bus error and exception.
// - Only hard reset restores defaults; soft init leaves contents alone.
// - An enabled fixed range wins over any variable pair.
// - One fixed-enable bit in default type register gates all fixed registers.
// - A pair takes part only while mask bit 11 is set.
// - After reset fixed-enable and all pair valid bits read cleared.
// - Pair hits when address AND mask equals base AND mask.
// - On a pair hit the type comes from base low bits.
// - Type field covers write-through, write-back, combining, protected, uncached.
// - Mask need not be contiguous; periodic holes are possible.
module mtr_range_lookup #(
  parameter int NVAR = mtr_pkg::NVAR_DEF,
  parameter bit FIX_IMPL = 1'b1
) (
  // Clock and hard reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mtr_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [mtr_pkg::WB_DW-1:0] wb_dat_i,
  output logic [mtr_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Exception toward the core
  output logic exc_o,
  // Lookup port
  input wire logic lk_valid_i,
  input wire logic [mtr_pkg::PA_W-1:0] lk_addr_i,
  output logic lk_valid_o,
  output logic [mtr_pkg::TYPE_MSB:0] lk_type_o,
  output logic [1:0] lk_src_o
);
  import mtr_pkg::*;

  localparam logic [WB_AW-1:0] FIX_END = OFS_FIX + FIX_STRIDE * WB_AW'(NFIX);
  localparam logic [WB_AW-1:0] VAR_END = OFS_VAR + VAR_STRIDE * WB_AW'(NVAR);

  // Merge a byte-enabled word into one half of a 64-bit register
  function automatic logic [63:0] merge_word(
    input logic [63:0] old_val,
    input logic hi,
    input logic [3:0] sel,
    input logic [31:0] dat,
    input logic [63:0] wmask
  );
    logic [63:0] nv;
    nv = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        if (hi) begin
          nv[32 + 8*b +: 8] = dat[8*b +: 8];
        end else begin
          nv[8*b +: 8] = dat[8*b +: 8];
        end
      end
    end
    return nv & wmask;
  endfunction

  // Register state
  logic [63:0] def_reg;
  logic [63:0] fix_reg [NFIX];
  logic [63:0] base_reg [NVAR];
  logic [63:0] mask_reg [NVAR];
  logic ack_reg;
  logic err_reg;
  logic [WB_DW-1:0] rdata_reg;
  logic lk_valid_reg;
  logic [TYPE_MSB:0] lk_type_reg;
  logic [1:0] lk_src_reg;

  // Bus decode
  wire req;
  wire wr;
  wire hi_word;
  wire is_cap;
  wire is_def;
  wire is_fix;
  wire is_var;
  wire mapped;
  wire [WB_AW-1:0] fix_rel;
  wire [WB_AW-1:0] var_rel;
  wire [WB_AW-4:0] fix_idx;
  wire [WB_AW-5:0] var_idx;
  wire var_is_mask;
  wire [63:0] cap_val;

  assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign wr = req && wb_we_i;
  assign hi_word = wb_adr_i[2];
  assign fix_rel = wb_adr_i - OFS_FIX;
  assign var_rel = wb_adr_i - OFS_VAR;
  assign fix_idx = fix_rel[WB_AW-1:3];
  assign var_idx = var_rel[WB_AW-1:4];
  assign var_is_mask = var_rel[3];
  assign is_cap = wb_adr_i[WB_AW-1:3] == OFS_CAP[WB_AW-1:3];
  assign is_def = wb_adr_i[WB_AW-1:3] == OFS_DEF[WB_AW-1:3];
  assign is_fix = FIX_IMPL && (wb_adr_i >= OFS_FIX) && (wb_adr_i < FIX_END);
  assign is_var = (wb_adr_i >= OFS_VAR) && (wb_adr_i < VAR_END);
  // Capability is read-only, so writing it counts as unmapped
  assign mapped = (is_cap && !wb_we_i) || is_def || is_fix || is_var;

  // Capability: pair count, fixed support, combining support
  assign cap_val[63:CAP_WC_BIT+1] = '0;
  assign cap_val[CAP_WC_BIT] = 1'b1;
  assign cap_val[CAP_WC_BIT-1:CAP_FIX_BIT+1] = '0;
  assign cap_val[CAP_FIX_BIT] = FIX_IMPL;
  assign cap_val[CAP_VCNT_MSB:0] = (CAP_VCNT_MSB+1)'(NVAR);

  // Per-register write strobes
  wire def_we;
  wire [NFIX-1:0] fix_we;
  wire [NVAR-1:0] base_we;
  wire [NVAR-1:0] mask_we;

  assign def_we = wr && is_def;

  genvar g;
  generate
    for (g = 0; g < NFIX; g++) begin : g_fix
      assign fix_we[g] = wr && is_fix && (fix_idx == (WB_AW-3)'(g));
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          fix_reg[g] <= RANGE_RST;
        end else if (fix_we[g]) begin
          fix_reg[g] <= merge_word(fix_reg[g], hi_word, wb_sel_i, wb_dat_i, FIX_WMASK);
        end
      end
    end
  endgenerate

  // Variable pairs and their comparators
  wire [NVAR-1:0] var_hit;
  logic [TYPE_MSB:0] var_type [NVAR];

  generate
    for (g = 0; g < NVAR; g++) begin : g_var
      mtr_pair_if pif ();
      assign base_we[g] = wr && is_var && !var_is_mask && (var_idx == (WB_AW-4)'(g));
      assign mask_we[g] = wr && is_var && var_is_mask && (var_idx == (WB_AW-4)'(g));
      assign pif.addr = lk_addr_i;
      assign pif.base = base_reg[g];
      assign pif.mask = mask_reg[g];
      assign var_hit[g] = pif.hit;
      assign var_type[g] = pif.mtype;
      mtr_pair_match u_match (
        .pair (pif)
      );
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          base_reg[g] <= RANGE_RST;
          mask_reg[g] <= RANGE_RST;
        end else begin
          if (base_we[g]) begin
            base_reg[g] <= merge_word(base_reg[g], hi_word, wb_sel_i, wb_dat_i, BASE_WMASK);
          end
          if (mask_we[g]) begin
            mask_reg[g] <= merge_word(mask_reg[g], hi_word, wb_sel_i, wb_dat_i, MASK_WMASK);
          end
        end
      end
    end
  endgenerate

  // Default type register; hard reset clears fixed-enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      def_reg <= RANGE_RST;
    end else if (def_we) begin
      def_reg <= merge_word(def_reg, hi_word, wb_sel_i, wb_dat_i, DEF_WMASK);
    end
  end

  // Read data select
  logic [63:0] rd_full;
  wire [WB_DW-1:0] rd_word;

  always_comb begin
    rd_full = 64'h0;
    if (is_cap) begin
      rd_full = cap_val;
    end else if (is_def) begin
      rd_full = def_reg;
    end else if (is_fix) begin
      for (int i = 0; i < NFIX; i++) begin
        if (fix_idx == (WB_AW-3)'(i)) begin
          rd_full = fix_reg[i];
        end
      end
    end else if (is_var) begin
      for (int i = 0; i < NVAR; i++) begin
        if (var_idx == (WB_AW-4)'(i)) begin
          rd_full = var_is_mask ? mask_reg[i] : base_reg[i];
        end
      end
    end
  end

  assign rd_word = hi_word ? rd_full[63:32] : rd_full[31:0];

  // Bus answer one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req && mapped;
      err_reg <= req && !mapped;
      if (req && mapped && !wb_we_i) begin
        rdata_reg <= rd_word;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign exc_o = err_reg;
  assign wb_dat_o = rdata_reg;

  // Lookup: fixed, then variable, then default
  wire below_1mb;
  wire fix_en;
  wire [2:0] fix_sel;
  wire [2:0] sub_sel;
  wire [TYPE_MSB:0] fix_type;
  logic var_any;
  logic var_uc;
  logic [TYPE_MSB:0] var_first;
  logic [TYPE_MSB:0] lk_type_next;
  logic [1:0] lk_src_next;

  assign below_1mb = lk_addr_i[PA_W-1:FIX_TOP_BIT] == '0;
  assign fix_en = FIX_IMPL && def_reg[DEF_FE_BIT];
  assign fix_sel = lk_addr_i[FIX_TOP_BIT-1:FIX_REG_LSB];
  assign sub_sel = lk_addr_i[FIX_REG_LSB-1:FIX_SUB_LSB];
  assign fix_type = fix_reg[fix_sel][8*sub_sel +: 8];

  // Lowest pair wins, except that any uncached hit wins over all
  always_comb begin
    var_any = 1'b0;
    var_uc = 1'b0;
    var_first = MTR_UC;
    for (int i = NVAR - 1; i >= 0; i--) begin
      if (var_hit[i]) begin
        var_any = 1'b1;
        var_first = var_type[i];
        if (var_type[i] == MTR_UC) begin
          var_uc = 1'b1;
        end
      end
    end
  end

  always_comb begin
    if (below_1mb && fix_en) begin
      lk_type_next = fix_type;
      lk_src_next = MTR_SRC_FIXED;
    end else if (var_any) begin
      lk_type_next = var_uc ? MTR_UC : var_first;
      lk_src_next = MTR_SRC_VAR;
    end else begin
      lk_type_next = def_reg[TYPE_MSB:0];
      lk_src_next = MTR_SRC_DEFAULT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk_valid_reg <= 1'b0;
      lk_type_reg <= MTR_UC;
      lk_src_reg <= MTR_SRC_DEFAULT;
    end else begin
      lk_valid_reg <= lk_valid_i;
      if (lk_valid_i) begin
        lk_type_reg <= lk_type_next;
        lk_src_reg <= lk_src_next;
      end
    end
  end

  assign lk_valid_o = lk_valid_reg;
  assign lk_type_o = lk_type_reg;
  assign lk_src_o = lk_src_reg;
endmodule

/* File: verification/mtr_range_lookup_sva.sv */
// Port-level checks of the range lookup block.
// Assumes binding onto mtr_range_lookup with its parameters.
module mtr_range_lookup_sva #(
  parameter int NVAR = mtr_pkg::NVAR_DEF,
  parameter bit FIX_IMPL = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mtr_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [mtr_pkg::WB_DW-1:0] wb_dat_i,
  input wire logic [mtr_pkg::WB_DW-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic exc_o,
  // Lookup
  input wire logic lk_valid_i,
  input wire logic [mtr_pkg::PA_W-1:0] lk_addr_i,
  input wire logic lk_valid_o,
  input wire logic [mtr_pkg::TYPE_MSB:0] lk_type_o,
  input wire logic [1:0] lk_src_o
);
  import mtr_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_ans;
    (wb_ack_o ^ wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
  endsequence
  chk_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus request not answered in one cycle");
  chk_err_exc_pair: assert property (wb_err_o == exc_o)
    else $error("exception differs from bus error");
  chk_err_cause: assert property (wb_err_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus error without request");
  chk_lk_answer: assert property (lk_valid_i |=> lk_valid_o)
    else $error("lookup not answered");
  chk_lk_hold: assert property (!lk_valid_i |=> !lk_valid_o && $stable({lk_type_o, lk_src_o}))
    else $error("lookup result changed without request");
  chk_fixed_window: assert property ((lk_valid_i && lk_addr_i[35:20] != 16'h0) |=> lk_src_o != 2'h1)
    else $error("fixed source above one megabyte");
  chk_src_legal: assert property (lk_valid_o |-> lk_src_o != 2'h2)
    else $error("illegal lookup source");
  chk_reset_clear: assert property ($fell(rst_i) |-> !wb_ack_o && !lk_valid_o && lk_src_o == 2'h0)
    else $error("outputs not clear after reset");
endmodule

bind mtr_range_lookup mtr_range_lookup_sva #(.NVAR(NVAR), .FIX_IMPL(FIX_IMPL)) i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .exc_o(exc_o), .lk_valid_i(lk_valid_i),
  .lk_addr_i(lk_addr_i), .lk_valid_o(lk_valid_o), .lk_type_o(lk_type_o), .lk_src_o(lk_src_o));

/* File: verification/mtr_range_lookup_test.sv */
// Self-checking bench of the range lookup block.
// Assumes the checker binds itself from its own file.
module mtr_range_lookup_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mtr_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, lk_valid_i;
  logic [WB_AW-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [WB_DW-1:0] wb_dat_i, wb_dat_o, rd;
  logic wb_ack_o, wb_err_o, exc_o, lk_valid_o, er;
  logic [PA_W-1:0] lk_addr_i;
  logic [TYPE_MSB:0] lk_type_o;
  logic [1:0] lk_src_o;
  logic [7:0] tl [5] = '{MTR_UC, MTR_WC, MTR_WT, MTR_WP, MTR_WB};
  int n_errors = 0;
  int n_tests = 0;

  mtr_range_lookup #(.NVAR(8), .FIX_IMPL(1'b1)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .exc_o(exc_o), .lk_valid_i(lk_valid_i),
    .lk_addr_i(lk_addr_i), .lk_valid_o(lk_valid_o), .lk_type_o(lk_type_o), .lk_src_o(lk_src_o));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic results();
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_lk(input logic [7:0] t, input logic [1:0] s);
    n_tests++;
    if ({lk_valid_o, lk_src_o, lk_type_o} !== {1'b1, s, t}) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, {lk_valid_o, lk_src_o, lk_type_o}, {1'b1, s, t});
    end
  endtask

  // One classic cycle, held until ack or err
  task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr64(input logic [11:0] adr, input logic [63:0] v);
    wb_xfer(1'b1, adr, v[31:0]);
    wb_xfer(1'b1, adr + 12'h004, v[63:32]);
  endtask

  task automatic set_pair_at(input logic [3:0] p, input logic [63:0] b, input logic [63:0] m);
    logic [WB_AW-1:0] a;
    a = OFS_VAR + VAR_STRIDE * {8'h0, p};
    wr64(a + 12'h008, 64'h0);
    wr64(a, b);
    wr64(a + 12'h008, m);
  endtask

  task automatic set_pair(input logic [63:0] b, input logic [63:0] m);
    set_pair_at(4'h0, b, m);
  endtask

  // Zero every range register, the two top pairs included
  task automatic clear_all();
    wr64(OFS_DEF, 64'h0);
    for (int i = 0; i < NFIX; i++) begin
      wr64(OFS_FIX + FIX_STRIDE * WB_AW'(i), 64'h0);
    end
    for (int i = 0; i < 8; i++) begin
      wr64(OFS_VAR + VAR_STRIDE * WB_AW'(i) + 12'h008, 64'h0);
      wr64(OFS_VAR + VAR_STRIDE * WB_AW'(i), 64'h0);
    end
  endtask

  task automatic lkp(input logic [PA_W-1:0] adr, input logic [7:0] t, input logic [1:0] s);
    @(posedge clk_i);
    lk_valid_i <= 1'b1;
    lk_addr_i <= adr;
    @(posedge clk_i);
    lk_valid_i <= 1'b0;
    #1;
    check_lk(t, s);
  endtask

  function automatic logic f_hit(input logic [35:0] ad, input logic [63:0] b, input logic [63:0] m);
    return m[11] && ((ad[35:12] & m[35:12]) == (b[35:12] & m[35:12]));
  endfunction

  // Random addresses above 1 MB, half forced onto the pair
  task automatic lk_rand(input logic [63:0] b, input logic [63:0] m, input logic [7:0] d);
    logic [35:0] a;
    repeat (16) begin
      a = 36'({$urandom(), $urandom()}) | 36'h0_0010_0000;
      if ($urandom() % 2) a = a & ~m[35:0] | 36'h0_0010_0000 & ~m[35:0];
      lkp(a, f_hit(a, b, m) ? b[7:0] : d, f_hit(a, b, m) ? 2'h3 : 2'h0);
    end
  endtask

  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    lk_valid_i = 1'b0;
    lk_addr_i = 36'h0;
    void'($urandom(32'he8d1));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, OFS_DEF, 32'h0);
    check_word(rd, 32'h0);
    wb_xfer(1'b0, OFS_VAR + 12'h008, 32'h0);
    check_word(rd, 32'h0);
    clear_all();
    wb_xfer(1'b1, OFS_CAP, 32'hFFFF_FFFF);
    check_word({31'h0, er}, 32'h1);
    wb_xfer(1'b0, OFS_CAP, 32'h0);
    check_word(rd, 32'h0000_0508);
    wb_xfer(1'b1, 12'h0F0, 32'h1);
    check_word({31'h0, er}, 32'h1);
    lkp(36'h0_0000_4000, 8'h00, 2'h0);
    wr64(OFS_DEF, 64'h4);
    check_word({31'h0, er}, 32'h0);
    wr64(OFS_VAR, 64'hFFFF_FFFF_FFFF_FFFF);
    wb_xfer(1'b0, OFS_VAR, 32'h0);
    check_word(rd, 32'hFFFF_F0FF);
    wb_xfer(1'b0, OFS_VAR + 12'h004, 32'h0);
    check_word(rd, 32'h0000_000F);
    set_pair(64'h6, 64'hF_FC00_0800);
    lk_rand(64'h6, 64'hF_FC00_0800, 8'h04);
    wr64(OFS_VAR + 12'h008, 64'hF_FC00_0000);
    lkp(36'h0_0123_4000, 8'h04, 2'h0);
    foreach (tl[i]) begin
      set_pair({56'h0, tl[i]}, 64'hF_FC00_0800);
      lkp(36'h0_0123_4000, tl[i], 2'h3);
    end
    set_pair(64'h0, 64'h0_00FF_F800);
    lk_rand(64'h0, 64'h0_00FF_F800, 8'h04);
    wr64(OFS_FIX, 64'h0505_0505_0505_0505);
    set_pair(64'h6, 64'hF_FC00_0800);
    lkp(36'h0_0000_4000, 8'h06, 2'h3);
    wr64(OFS_DEF, 64'h404);
    wb_xfer(1'b0, OFS_DEF, 32'h0);
    check_word(rd, 32'h0000_0404);
    lkp(36'h0_0000_4000, 8'h05, 2'h1);
    lkp(36'h0_0010_0000, 8'h06, 2'h3);
    set_pair_at(4'h1, 64'h0_0400_0006, 64'hF_FE00_0800);
    set_pair_at(4'h2, 64'h0_0500_0000, 64'hF_FFFF_F800);
    lkp(36'h0_0500_0000, MTR_UC, 2'h3);
    lkp(36'h0_0500_1000, MTR_WB, 2'h3);
    lkp(36'h0_03FF_F000, MTR_WB, 2'h3);
    lkp(36'h0_0600_0000, 8'h04, 2'h0);
    // Hard reset in mid-run restores the defaults
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, OFS_VAR, 32'h0);
    check_word(rd, 32'h0);
    wb_xfer(1'b0, OFS_DEF, 32'h0);
    check_word(rd, 32'h0);
    lkp(36'h0_0000_4000, MTR_UC, 2'h0);
    results();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    results();
  end
endmodule
